/* File: rtl/dspb_defs.svh */
// offsets, field positions, reset values and startup loads of the drive startup parameter bank
`ifndef DSPB_DEFS_SVH
`define DSPB_DEFS_SVH
`define DSPB_ADDR_LIMREL     16'h060c
`define DSPB_ADDR_OPMODE     16'h1b06
`define DSPB_ADDR_ALIAS      16'h0012
`define DSPB_ADDR_SWADDR     16'h0ffe
`define DSPB_ADDR_SCALE_DEN  16'h1550
`define DSPB_ADDR_SCALE_NUM  16'h1552
`define DSPB_LIMREL_RST      16'h0000
`define DSPB_LIMREL_START    16'h0002
`define DSPB_LIMREL_MAX      16'h0002
`define DSPB_OPMODE_RST      16'h0000
`define DSPB_OPMODE_START    16'h0008
`define DSPB_SCALE_DEN_START 32'h00008000
`define DSPB_SCALE_NUM_START 32'h00000001
`define DSPB_ALIAS_RST       16'h0000
`define DSPB_OPMODE_CSP      16'h0008
`define DSPB_OPMODE_SPEED    16'hfffc
`define DSPB_OPMODE_JOG      16'hffff
`define DSPB_OPMODE_PPOS     16'h0001
`define DSPB_OPMODE_PVEL     16'h0003
`define DSPB_OPMODE_HOME     16'h0006
`define DSPB_SW_LO_LSB       0
`define DSPB_SW_HI_LSB       4
`endif

/* File: rtl/dspb_pkg.sv */
// types shared by the drive startup parameter bank
package dspb_pkg;
  typedef enum logic [1:0] {
    DSPB_VIA_MODBUS,
    DSPB_VIA_CANOPEN
  } dspb_path_e;
  typedef enum logic [2:0] {
    DSPB_FB_INIT,
    DSPB_FB_PREOP,
    DSPB_FB_SAFEOP,
    DSPB_FB_OP,
    DSPB_FB_BOOT
  } dspb_fbstate_e;
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    dspb_path_e path;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dspb_req_s;
  typedef struct packed {
    logic        valid;
    logic        ack;
    logic        err;
    logic [15:0] rdata;
  } dspb_rsp_s;
  typedef struct packed {
    logic       releaseAllowed;
    logic       ignoreAtEnable;
  } dspb_limcfg_s;
endpackage

/* File: rtl/dspb_sync2.sv */
// two-flop synchroniser for a bus of pin levels
`timescale 1ns/10ps
`default_nettype none
module dspb_sync2 #(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;
  // first stage read only by the second
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/dspb_bank.sv */
// drive startup parameter bank: limit release, operating mode, station address, web gate
`timescale 1ns/10ps
`default_nettype none
`include "dspb_defs.svh"
// Functional notes
// (R1) release setting: 0 off, 1 reset, 2 also ignore
// (R2) release only acts in cyclic synchronous modes
// (R3) release writes only while stage disabled; apply at enable
// (R4) startup loads release setting value 2
// (R5) mode decode; startup loads cyclic synchronous position
// (R6) mode write takes effect immediately
// (R7) mode 16-bit on Modbus, 8-bit on CANopen
// (R8) identification supplies fixed station address
// (R9) alias address kept at offset 12 hex
// (R10) new alias used only after power cycle
// (R11) switch address readable at offset 0FFE hex
// (R12) low switch low digit, high switch high
// (R13) web answers only in pre-operational or higher
// (R14) web requires valid IP address
// (R15) startup loads scaling denominator 32768, numerator 1
// (R16) out-of-range release writes rejected, value kept
module dspb_bank (
  input  wire logic                   mclk,
  input  wire logic                   reset_n,
  input  wire dspb_pkg::dspb_req_s    busReq,
  output dspb_pkg::dspb_rsp_s         busRsp,
  input  wire logic                   startupLoad,
  input  wire logic                   powerStageEnabled,
  input  wire logic                   limitActiveAtEnable,
  input  wire logic [3:0]             addressSwitchLow,
  input  wire logic [3:0]             addressSwitchHigh,
  input  wire logic                   identEnable,
  input  wire logic                   identUseSwitches,
  input  wire dspb_pkg::dspb_fbstate_e fieldbusState,
  input  wire logic                   ipAddressValid,
  input  wire logic                   webConnectReq,
  output logic                        webConnectAccept,
  output logic                        webConnectRefuse,
  output logic                        webEnabled,
  output dspb_pkg::dspb_limcfg_s      limitCfg,
  output logic                        suppressActiveLimitErr,
  output logic                        cyclicSyncMode,
  output logic [15:0]                 operatingModeActive,
  output logic                        staticAddrValid,
  output logic [15:0]                 staticAddress,
  output logic [31:0]                 positionScaleDenominator,
  output logic [31:0]                 positionScaleNumerator
);
  import dspb_pkg::*;

  logic [15:0] limitReleaseSetting_q;
  logic [15:0] limitReleaseApplied_q;
  logic [15:0] operatingModeSelect_q;
  logic [15:0] aliasStored_q = `DSPB_ALIAS_RST;  // power-on content of the non-volatile store
  logic [15:0] aliasActive_q;
  logic        aliasLatched_q;
  logic [31:0] scaleDen_q;
  logic [31:0] scaleNum_q;
  logic        stageEn_q;
  logic [7:0]  switchSync;
  logic [7:0]  switchAddr;
  logic        wrLimrel;
  logic        wrLimrelOk;
  logic        wrOpmode;
  logic        wrAlias;
  logic        addrHit;
  logic        wrRefused;
  dspb_rsp_s   rsp_d;

  // sign-extend a CANopen 8-bit value to the 16-bit store
  function automatic logic [15:0] sext8(input logic [7:0] v);
    sext8 = {{8{v[7]}}, v};
  endfunction

  // true for the cyclic synchronous position mode only
  function automatic logic isCyclicSync(input logic [15:0] m);
    isCyclicSync = (m == `DSPB_OPMODE_CSP);
  endfunction

  // true for the documented mode encodings
  function automatic logic isKnownMode(input logic [15:0] m);
    case (m)
      `DSPB_OPMODE_SPEED, `DSPB_OPMODE_JOG, `DSPB_OPMODE_PPOS,
      `DSPB_OPMODE_PVEL, `DSPB_OPMODE_HOME, `DSPB_OPMODE_CSP: isKnownMode = 1'b1;
      default: isKnownMode = 1'b0;
    endcase
  endfunction

  // rotary switches are pins, so they are synchronised first
  dspb_sync2 #(
    .W (8)
  ) u_swsync (
    .mclk    (mclk),
    .reset_n (reset_n),
    .din     ({addressSwitchHigh, addressSwitchLow}),
    .dout    (switchSync)
  );

  // high switch is the sixteens digit, low switch the ones digit
  assign switchAddr = {switchSync[`DSPB_SW_HI_LSB+3:`DSPB_SW_HI_LSB],
                       switchSync[`DSPB_SW_LO_LSB+3:`DSPB_SW_LO_LSB]};  // [R12]

  // write decode
  assign wrLimrel   = busReq.wrEn && (busReq.addr == `DSPB_ADDR_LIMREL);
  assign wrLimrelOk = wrLimrel && !powerStageEnabled                     // [R3]
                      && (busReq.wdata <= `DSPB_LIMREL_MAX);             // [R16]
  assign wrOpmode   = busReq.wrEn && (busReq.addr == `DSPB_ADDR_OPMODE);
  assign wrAlias    = busReq.wrEn && (busReq.addr == `DSPB_ADDR_ALIAS);
  assign wrRefused  = wrLimrel && !wrLimrelOk;

  // release setting: startup load wins, else guarded writes
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      limitReleaseSetting_q <= `DSPB_LIMREL_RST;
    end else if (startupLoad) begin
      limitReleaseSetting_q <= `DSPB_LIMREL_START;  // [R4]
    end else if (wrLimrelOk) begin
      limitReleaseSetting_q <= busReq.wdata;       // [R3]
    end
  end

  // copy the setting into use on the rising edge of stage enable
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      stageEn_q             <= 1'b0;
      limitReleaseApplied_q <= `DSPB_LIMREL_RST;
    end else begin
      stageEn_q <= powerStageEnabled;
      if (powerStageEnabled && !stageEn_q) begin
        limitReleaseApplied_q <= limitReleaseSetting_q;  // [R3]
      end
    end
  end

  // operating mode: immediate; CANopen writes carry only 8 bits
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      operatingModeSelect_q <= `DSPB_OPMODE_RST;
    end else if (startupLoad) begin
      operatingModeSelect_q <= `DSPB_OPMODE_START;  // [R5]
    end else if (wrOpmode) begin
      if (busReq.path == DSPB_VIA_CANOPEN) begin
        operatingModeSelect_q <= sext8(busReq.wdata[7:0]);  // [R7]
      end else begin
        operatingModeSelect_q <= busReq.wdata;              // [R6]
      end
    end
  end

  // scaling pair loaded by the startup set
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      scaleDen_q <= '0;
      scaleNum_q <= '0;
    end else if (startupLoad) begin
      scaleDen_q <= `DSPB_SCALE_DEN_START;  // [R15]
      scaleNum_q <= `DSPB_SCALE_NUM_START;  // [R15]
    end
  end

  // alias store has no reset: reset stands for a power cycle, which must not lose it
  always_ff @(posedge mclk) begin
    if (reset_n && wrAlias) begin
      aliasStored_q <= busReq.wdata;  // [R9]
    end
  end

  // active alias taken from the store once, at the first edge after reset
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      aliasActive_q  <= `DSPB_ALIAS_RST;
      aliasLatched_q <= 1'b0;
    end else if (!aliasLatched_q) begin
      aliasActive_q  <= aliasStored_q;  // [R10]
      aliasLatched_q <= 1'b1;
    end
  end

  // read and answer, one cycle after the request
  always_comb begin
    rsp_d   = '0;
    addrHit = 1'b1;
    case (busReq.addr)
      `DSPB_ADDR_LIMREL: rsp_d.rdata = limitReleaseSetting_q;
      `DSPB_ADDR_OPMODE: begin
        if (busReq.path == DSPB_VIA_CANOPEN) begin
          rsp_d.rdata = sext8(operatingModeSelect_q[7:0]);  // [R7]
        end else begin
          rsp_d.rdata = operatingModeSelect_q;
        end
      end
      `DSPB_ADDR_ALIAS:     rsp_d.rdata = aliasStored_q;           // [R9]
      `DSPB_ADDR_SWADDR:    rsp_d.rdata = {8'h00, switchAddr};     // [R11]
      `DSPB_ADDR_SCALE_DEN: rsp_d.rdata = scaleDen_q[15:0];
      `DSPB_ADDR_SCALE_NUM: rsp_d.rdata = scaleNum_q[15:0];
      default: addrHit = 1'b0;
    endcase
    rsp_d.valid = busReq.wrEn || busReq.rdEn;
    rsp_d.err   = rsp_d.valid && (!addrHit || (busReq.wrEn && wrRefused)
                  || (busReq.wrEn && busReq.addr == `DSPB_ADDR_SWADDR));
    rsp_d.ack   = rsp_d.valid && !rsp_d.err;
    if (!busReq.rdEn || rsp_d.err) begin
      rsp_d.rdata = 16'h0000;
    end
  end

  // registered answer
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      busRsp <= '0;
    end else begin
      busRsp <= rsp_d;
    end
  end

  // release behaviour decoded from the applied copy, gated by mode
  always_comb begin
    limitCfg.releaseAllowed = 1'b0;
    limitCfg.ignoreAtEnable = 1'b0;
    if (isCyclicSync(operatingModeSelect_q)) begin  // [R2]
      limitCfg.releaseAllowed = (limitReleaseApplied_q == 16'h0001)
                                || (limitReleaseApplied_q == 16'h0002);  // [R1]
      limitCfg.ignoreAtEnable = (limitReleaseApplied_q == 16'h0002);     // [R1]
    end
  end

  assign suppressActiveLimitErr = limitCfg.ignoreAtEnable && limitActiveAtEnable;  // [R1]
  assign cyclicSyncMode         = isCyclicSync(operatingModeSelect_q) && isKnownMode(operatingModeSelect_q);
  assign operatingModeActive    = operatingModeSelect_q;  // [R6]
  assign positionScaleDenominator = scaleDen_q;
  assign positionScaleNumerator   = scaleNum_q;

  // station address from chosen identification method
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      staticAddrValid <= 1'b0;
      staticAddress   <= 16'h0000;
    end else begin
      staticAddrValid <= identEnable;  // [R8]
      staticAddress   <= identUseSwitches ? {8'h00, switchAddr} : aliasActive_q;  // [R8]
    end
  end

  // web gate: pre-operational or above, and valid IP
  always_comb begin
    webEnabled = (fieldbusState == DSPB_FB_PREOP) || (fieldbusState == DSPB_FB_SAFEOP)
                 || (fieldbusState == DSPB_FB_OP);  // [R13]
  end
  assign webConnectAccept = webConnectReq && webEnabled && ipAddressValid;        // [R14]
  assign webConnectRefuse = webConnectReq && !(webEnabled && ipAddressValid);     // [R14]
endmodule
`default_nettype wire

/* File: bench/dspb_bank_assertions.sv */
// port checker for the drive startup parameter bank
`timescale 1ns/10ps
`default_nettype none
module dspb_bank_assertions (
  input wire logic                    mclk,
  input wire logic                    reset_n,
  input wire dspb_pkg::dspb_req_s     busReq,
  input wire dspb_pkg::dspb_rsp_s     busRsp,
  input wire logic                    startupLoad,
  input wire logic                    powerStageEnabled,
  input wire dspb_pkg::dspb_fbstate_e fieldbusState,
  input wire logic                    ipAddressValid,
  input wire logic                    webConnectReq,
  input wire logic                    webConnectRefuse,
  input wire logic                    webEnabled,
  input wire logic                    suppressActiveLimitErr,
  input wire logic                    cyclicSyncMode,
  input wire logic [15:0]             operatingModeActive,
  input wire logic [31:0]             positionScaleDenominator,
  input wire logic [31:0]             positionScaleNumerator
);
  import dspb_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // release writes are address 060c
  wire relWr = busReq.wrEn && busReq.addr == 16'h060c;
  property p_stage; relWr && powerStageEnabled |=> busRsp.valid && busRsp.err; endproperty
  a_stage: assert property (p_stage) else $error("release write taken while stage on");
  property p_range; relWr && busReq.wdata > 16'h0002 |=> busRsp.err; endproperty
  a_range: assert property (p_range) else $error("release value above 2 taken");
  property p_scale;
    startupLoad |=> positionScaleDenominator == 32'h00008000 && positionScaleNumerator == 32'h00000001;
  endproperty
  a_scale: assert property (p_scale) else $error("startup scaling wrong");
  property p_boot; startupLoad |=> operatingModeActive == 16'h0008 && cyclicSyncMode; endproperty
  a_boot: assert property (p_boot) else $error("startup mode wrong");
  property p_now;
    busReq.wrEn && busReq.addr == 16'h1b06 && busReq.path == DSPB_VIA_MODBUS && !startupLoad
      |=> operatingModeActive == $past(busReq.wdata);
  endproperty
  a_now: assert property (p_now) else $error("mode write not applied at once");
  property p_cyc; !cyclicSyncMode |-> !suppressActiveLimitErr; endproperty
  a_cyc: assert property (p_cyc) else $error("suppression outside cyclic mode");
  property p_web; webEnabled == (fieldbusState inside {DSPB_FB_PREOP, DSPB_FB_SAFEOP, DSPB_FB_OP}); endproperty
  a_web: assert property (p_web) else $error("web gate wrong for state");
  property p_ip; webConnectReq && !ipAddressValid |-> webConnectRefuse; endproperty
  a_ip: assert property (p_ip) else $error("connection kept without address");
  property p_can;
    busReq.rdEn && busReq.path == DSPB_VIA_CANOPEN && busReq.addr == 16'h1b06
      |=> busRsp.rdata[15:8] == {8{busRsp.rdata[7]}};
  endproperty
  a_can: assert property (p_can) else $error("byte mode read not sign extended");
  c_rel: cover property (relWr ##1 busRsp.ack);
  c_boot: cover property (startupLoad);
  c_ref: cover property (webConnectReq && webConnectRefuse);
endmodule
bind dspb_bank dspb_bank_assertions dspb_bank_assertions_i (.mclk, .reset_n, .busReq, .busRsp, .startupLoad,
  .powerStageEnabled, .fieldbusState, .ipAddressValid, .webConnectReq, .webConnectRefuse, .webEnabled,
  .suppressActiveLimitErr, .cyclicSyncMode, .operatingModeActive, .positionScaleDenominator,
  .positionScaleNumerator);
`default_nettype wire

/* File: bench/dspb_master.sv */
// fieldbus master model issuing requests and startup loads
`timescale 1ns/10ps
`default_nettype none
module dspb_master (
  input  wire logic                mclk,
  input  wire dspb_pkg::dspb_rsp_s busRsp,
  output dspb_pkg::dspb_req_s      busReq,
  output logic                     startupLoad
);
  import dspb_pkg::*;
  dspb_rsp_s rsp;
  // idle at time zero
  initial begin
    busReq = '0;
    startupLoad = 1'b0;
  end
  // one-cycle request, answer taken one edge later
  task automatic xfer(input logic w, input dspb_path_e p, input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    #1 busReq = '{w, !w, p, a, d};
    @(posedge mclk);
    #1 rsp = busRsp;
    // released address and data show the inverse, so stale values never pass
    busReq = '{1'b0, 1'b0, p, ~a, ~d};
  endtask
  // startup parameter list load
  task automatic startup;
    @(posedge mclk);
    #1 startupLoad = 1'b1;
    @(posedge mclk);
    #1 startupLoad = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: bench/dspb_bank_tb.sv */
// self-checking bench for the drive startup parameter bank
`timescale 1ns/10ps
`default_nettype none
module dspb_bank_tb;
  import dspb_pkg::*;
  logic mclk, reset_n, startupLoad, powerStageEnabled, limitActiveAtEnable, identEnable, identUseSwitches;
  logic ipAddressValid, webConnectReq, webConnectAccept, webConnectRefuse, webEnabled;
  logic suppressActiveLimitErr, cyclicSyncMode, staticAddrValid;
  logic [3:0] addressSwitchLow, addressSwitchHigh;
  logic [15:0] operatingModeActive, staticAddress;
  logic [31:0] positionScaleDenominator, positionScaleNumerator;
  logic [15:0] modes [6] = '{16'hfffc, 16'hffff, 16'h0001, 16'h0003, 16'h0006, 16'h0008};
  dspb_fbstate_e fieldbusState;
  dspb_req_s busReq;
  dspb_rsp_s busRsp;
  dspb_limcfg_s limitCfg;
  int nErrors, nCompared, cycles;
  dspb_bank dspb_bank_i (.mclk, .reset_n, .busReq, .busRsp, .startupLoad, .powerStageEnabled,
    .limitActiveAtEnable, .addressSwitchLow, .addressSwitchHigh, .identEnable, .identUseSwitches,
    .fieldbusState, .ipAddressValid, .webConnectReq, .webConnectAccept, .webConnectRefuse, .webEnabled,
    .limitCfg, .suppressActiveLimitErr, .cyclicSyncMode, .operatingModeActive, .staticAddrValid,
    .staticAddress, .positionScaleDenominator, .positionScaleNumerator);
  dspb_master dspb_master_i (.mclk, .busRsp, .busReq, .startupLoad);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      nErrors++;
      $display("[ERR] %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input dspb_path_e p, input logic [15:0] a, input logic [15:0] d, input logic e);
    dspb_master_i.xfer(1'b1, p, a, d);
    chk({dspb_master_i.rsp.valid, dspb_master_i.rsp.ack, dspb_master_i.rsp.err}, {1'b1, !e, e});
  endtask
  task automatic rd(input dspb_path_e p, input logic [15:0] a, input logic [15:0] d);
    dspb_master_i.xfer(1'b0, p, a, 16'h0000);
    chk({dspb_master_i.rsp.valid, dspb_master_i.rsp.ack, dspb_master_i.rsp.err, dspb_master_i.rsp.rdata},
        {3'b110, d});
  endtask
  task automatic report_and_stop;
    if (nErrors == 0 && nCompared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // 50 ns clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // hang guard, far above the seventy or so cycles the run needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      nErrors++;
      report_and_stop();
    end
  end
  // main sequence
  initial begin
    {reset_n, powerStageEnabled, limitActiveAtEnable, identEnable, identUseSwitches} = '0;
    {ipAddressValid, webConnectReq, addressSwitchLow, addressSwitchHigh} = '0;
    fieldbusState = DSPB_FB_INIT;
    repeat (4) @(posedge mclk);
    #1 reset_n = 1'b1;
    rd(DSPB_VIA_MODBUS, 16'h060c, 16'h0000);
    dspb_master_i.startup();
    chk(positionScaleDenominator, 32'h00008000);
    chk(positionScaleNumerator, 32'h00000001);
    chk(operatingModeActive, 16'h0008);
    rd(DSPB_VIA_MODBUS, 16'h1550, 16'h8000);
    rd(DSPB_VIA_MODBUS, 16'h060c, 16'h0002);
    wr(DSPB_VIA_MODBUS, 16'h060c, 16'h0001, 1'b0);
    chk(limitCfg, 2'b00);
    powerStageEnabled = 1'b1;
    @(posedge mclk);
    #1 chk(limitCfg, 2'b10);
    wr(DSPB_VIA_MODBUS, 16'h060c, 16'h0000, 1'b1);
    powerStageEnabled = 1'b0;
    wr(DSPB_VIA_MODBUS, 16'h060c, 16'h0003, 1'b1);
    rd(DSPB_VIA_MODBUS, 16'h060c, 16'h0001);
    wr(DSPB_VIA_MODBUS, 16'h060c, 16'h0002, 1'b0);
    powerStageEnabled = 1'b1;
    limitActiveAtEnable = 1'b1;
    @(posedge mclk);
    #1 chk({limitCfg, suppressActiveLimitErr}, 3'b111);
    // every mode code, applied without any enable or restart
    foreach (modes[i]) begin
      wr(DSPB_VIA_MODBUS, 16'h1b06, modes[i], 1'b0);
      chk(operatingModeActive, modes[i]);
      chk({cyclicSyncMode, suppressActiveLimitErr}, {2{modes[i] == 16'h0008}});
    end
    wr(DSPB_VIA_CANOPEN, 16'h1b06, 16'h00fc, 1'b0);
    rd(DSPB_VIA_MODBUS, 16'h1b06, 16'hfffc);
    rd(DSPB_VIA_CANOPEN, 16'h1b06, 16'hfffc);
    identEnable = 1'b1;
    wr(DSPB_VIA_MODBUS, 16'h0012, 16'h005a, 1'b0);
    rd(DSPB_VIA_MODBUS, 16'h0012, 16'h005a);
    chk(staticAddress, 16'h0000);
    // power cycle: the stored alias survives and only now goes into use
    reset_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1 reset_n = 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk({staticAddrValid, staticAddress}, {1'b1, 16'h005a});
    rd(DSPB_VIA_MODBUS, 16'h0012, 16'h005a);
    addressSwitchLow = 4'h3;
    addressSwitchHigh = 4'ha;
    repeat (3) @(posedge mclk);
    rd(DSPB_VIA_MODBUS, 16'h0ffe, 16'h00a3);
    wr(DSPB_VIA_MODBUS, 16'h0ffe, 16'h0001, 1'b1);
    wr(DSPB_VIA_MODBUS, 16'h0100, 16'h0001, 1'b1);
    identUseSwitches = 1'b1;
    @(posedge mclk);
    #1 chk(staticAddress, 16'h00a3);
    // web gate over every fieldbus state
    for (int s = 0; s < 5; s++) begin
      fieldbusState = dspb_fbstate_e'(s);
      @(posedge mclk);
      #1 chk(webEnabled, s inside {1, 2, 3});
    end
    fieldbusState = DSPB_FB_OP;
    webConnectReq = 1'b1;
    @(posedge mclk);
    #1 chk({webConnectAccept, webConnectRefuse}, 2'b01);
    ipAddressValid = 1'b1;
    @(posedge mclk);
    #1 chk({webConnectAccept, webConnectRefuse}, 2'b10);
    report_and_stop();
  end
endmodule
`default_nettype wire
